// >>> rtl/isr_pkg.sv
// Purpose: Shared constants for the inductive sensor status and output block
// Assumes: 8-bit register port, one 10 MHz clock
// Notes: Impedance result codes are 8 bits wide
package isr_pkg;
    localparam logic [7:0] ADDR_IMP_CEIL = 8'h01;
    localparam logic [7:0] ADDR_IMP_FLOOR = 8'h02;
    localparam logic [7:0] ADDR_CONFIG = 8'h04;
    localparam logic [7:0] ADDR_THR_HIGH = 8'h07;
    localparam logic [7:0] ADDR_THR_LOW = 8'h09;
    localparam logic [7:0] ADDR_INT_FUNC = 8'h0A;
    localparam logic [7:0] ADDR_POWER = 8'h0B;
    localparam logic [7:0] ADDR_STATUS = 8'h20;
    localparam logic [7:0] ADDR_PROX = 8'h22;

    localparam logic [7:0] RST_IMP_CEIL = 8'h00;
    localparam logic [7:0] RST_IMP_FLOOR = 8'h14;
    localparam logic [7:0] RST_CONFIG = 8'h1B;
    localparam logic [7:0] RST_THR_HIGH = 8'hFF;
    localparam logic [7:0] RST_THR_LOW = 8'h00;
    localparam logic [7:0] RST_INT_FUNC = 8'h00;
    localparam logic [7:0] RST_POWER = 8'h00;
    localparam logic [7:0] RST_ZERO = 8'h00;

    localparam logic [2:0] INT_OFF = 3'h0;
    localparam logic [2:0] INT_WAKE = 3'h1;
    localparam logic [2:0] INT_COMP = 3'h2;
    localparam logic [2:0] INT_DRDY = 3'h4;

    localparam int RESP_W = 3;
    localparam int CNT_W = 11;
    localparam int RAW_W = 10;
    localparam logic [CNT_W-1:0] RATE_DIV = 11'h003;
    localparam logic [CNT_W-1:0] RESP_192 = 11'h0C0;
    localparam logic [CNT_W-1:0] RESP_384 = 11'h180;
    localparam logic [CNT_W-1:0] RESP_768 = 11'h300;
    localparam logic [CNT_W-1:0] RESP_1536 = 11'h600;
    localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
    localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
    localparam logic [RAW_W-1:0] RAW_MAX = 10'h0FF;

    // Counts 3072 and 6144 do not fit 11 bits, so thirds are held direct; 2048 truncates to 0 and wraps to last 2047
    localparam logic [CNT_W-1:0] PER_3072 = 11'h400;
    localparam logic [CNT_W-1:0] PER_6144 = 11'h0800;

    // Oscillator ticks per result, minus one: response count over three
    function automatic logic [CNT_W-1:0] isr_period_last(
        input logic [RESP_W-1:0] code);
        logic [CNT_W-1:0] per;
        per = RESP_192 / RATE_DIV;
        unique case (code)
            3'h3: per = RESP_384 / RATE_DIV;
            3'h4: per = RESP_768 / RATE_DIV;
            3'h5: per = RESP_1536 / RATE_DIV;
            3'h6: per = PER_3072;
            3'h7: per = PER_6144;
            default: per = RESP_192 / RATE_DIV;
        endcase
        return per - CNT_ONE;
    endfunction : isr_period_last

    // Clip a signed raw measurement into the 8-bit result range
    function automatic logic [7:0] isr_clip(input logic [RAW_W-1:0] raw);
        if (raw[RAW_W-1])
            return RST_ZERO;
        else if (raw > RAW_MAX)
            return 8'hFF;
        else
            return raw[7:0];
    endfunction : isr_clip
endpackage : isr_pkg

// >>> rtl/isr_rate_div.sv
// Purpose: Counts sensor oscillation ticks into one result pulse per period
// Assumes: i_osc_tick is a one-cycle pulse synchronous to i_sys_clk
// Notes: Counter restarts whenever conversion is disabled
`timescale 1ns/1ps
module isr_rate_div
    import isr_pkg::*;
(
    input wire logic i_sys_clk, // System clock
    input wire logic i_rst_n, // Synchronised reset, active low
    input wire logic i_enable, // Active conversion selected
    input wire logic i_osc_tick, // One pulse per sensor oscillation
    input wire logic [isr_pkg::RESP_W-1:0] i_resp_code, // Response field
    output logic o_conv_pulse // Result complete, one cycle
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    wire [CNT_W-1:0] last_w = isr_period_last(i_resp_code);
    wire at_end_w = i_enable && i_osc_tick && (cnt_reg >= last_w);

    assign cnt_next = !i_enable ? CNT_ZERO :
                      !i_osc_tick ? cnt_reg :
                      at_end_w ? CNT_ZERO : cnt_reg + CNT_ONE;
    assign o_conv_pulse = at_end_w;

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n)
            cnt_reg <= CNT_ZERO;
        else
            cnt_reg <= cnt_next;
    end

    a_rate_count_bound: assert property (
        @(posedge i_sys_clk) disable iff (!i_rst_n)
        (i_enable && cnt_reg <= last_w)
        ##1 (i_enable && $stable(i_resp_code)) |-> cnt_reg <= last_w)
        else $error("tick counter passed response period");
endmodule : isr_rate_div

// >>> rtl/isr_status_regs.sv
// Purpose: Control and status registers of an 8-bit inductive sensing converter
// Assumes: Register port strobes are one-cycle and synchronous to i_sys_clk
// Notes: Result register loads only when a read of it starts
`timescale 1ns/1ps
module isr_status_regs
    import isr_pkg::*;
(
    input wire logic i_sys_clk, // 10 MHz clock
    input wire logic i_arst_n, // Async reset, active low
    input wire logic i_reg_wr, // Register write strobe
    input wire logic i_reg_rd, // Register read start strobe
    input wire logic [7:0] i_reg_addr, // Register address
    input wire logic [7:0] i_reg_wdata, // Write data
    input wire logic i_osc_tick, // Sensor oscillation pulse
    input wire logic i_osc_overload, // Oscillator overloaded and stopped
    input wire logic [isr_pkg::RAW_W-1:0] i_raw_result, // Signed raw code
    output logic [7:0] o_reg_rdata, // Read data, registered
    output logic o_interrupt_pin_n, // Interrupt pin level
    output logic [7:0] o_impedance_floor_setting, // To front end
    output logic [7:0] o_impedance_ceiling_setting, // To front end
    output logic o_conversion_active_sel // Converting when high
);
    logic rst_meta_reg;
    logic rst_n_reg;
    logic [7:0] thr_low_reg;
    logic [7:0] thr_high_reg;
    logic [7:0] int_func_reg;
    logic [7:0] power_reg;
    logic [7:0] config_reg;
    logic [7:0] imp_floor_reg;
    logic [7:0] imp_ceil_reg;
    logic [7:0] pending_reg;
    logic [7:0] prox_reg;
    logic new_data_reg;
    logic comp_reg;
    logic wake_reg;
    logic overload_reg;
    logic [7:0] rdata_reg;
    logic conv_pulse;

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rst_meta_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n_reg <= rst_meta_reg;
        end
    end

    // Write decode; read-only addresses have no write enable
    wire wr_low_w = i_reg_wr && (i_reg_addr == ADDR_THR_LOW);
    wire wr_high_w = i_reg_wr && (i_reg_addr == ADDR_THR_HIGH);
    wire wr_int_w = i_reg_wr && (i_reg_addr == ADDR_INT_FUNC);
    wire wr_pwr_w = i_reg_wr && (i_reg_addr == ADDR_POWER);
    wire wr_cfg_w = i_reg_wr && (i_reg_addr == ADDR_CONFIG);
    wire wr_floor_w = i_reg_wr && (i_reg_addr == ADDR_IMP_FLOOR);
    wire wr_ceil_w = i_reg_wr && (i_reg_addr == ADDR_IMP_CEIL);
    wire rd_prox_w = i_reg_rd && (i_reg_addr == ADDR_PROX);

    wire active_w = power_reg[0];
    wire [2:0] int_mode_w = int_func_reg[2:0];
    wire [7:0] clip_w = isr_clip(i_raw_result);
    wire above_w = clip_w > thr_high_reg;
    wire below_w = clip_w < thr_low_reg;
    wire [7:0] status_w = {overload_reg, !new_data_reg, !wake_reg,
                           comp_reg, 4'h0};

    wire [7:0] rdata_next = (i_reg_addr == ADDR_THR_LOW) ? thr_low_reg :
        (i_reg_addr == ADDR_THR_HIGH) ? thr_high_reg :
        (i_reg_addr == ADDR_INT_FUNC) ? int_func_reg :
        (i_reg_addr == ADDR_POWER) ? power_reg :
        (i_reg_addr == ADDR_CONFIG) ? config_reg :
        (i_reg_addr == ADDR_IMP_FLOOR) ? imp_floor_reg :
        (i_reg_addr == ADDR_IMP_CEIL) ? imp_ceil_reg :
        (i_reg_addr == ADDR_STATUS) ? status_w :
        (i_reg_addr == ADDR_PROX) ? pending_reg : RST_ZERO;

    // New data wins over the clear made by a read in the same cycle
    wire new_data_next = conv_pulse ? 1'b1 :
                         rd_prox_w ? 1'b0 : new_data_reg;
    wire comp_next = (conv_pulse && below_w) ? 1'b1 :
                     (conv_pulse && above_w) ? 1'b0 : comp_reg;
    wire wake_next = (int_mode_w != INT_WAKE) ? 1'b0 :
                     (conv_pulse && above_w) ? 1'b1 : wake_reg;

    isr_rate_div u_rate_div (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(rst_n_reg),
        .i_enable(active_w),
        .i_osc_tick(i_osc_tick),
        .i_resp_code(config_reg[2:0]),
        .o_conv_pulse(conv_pulse)
    );

    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            thr_low_reg <= RST_THR_LOW;
            thr_high_reg <= RST_THR_HIGH;
            int_func_reg <= RST_INT_FUNC;
            power_reg <= RST_POWER;
            config_reg <= RST_CONFIG;
            imp_floor_reg <= RST_IMP_FLOOR;
            imp_ceil_reg <= RST_IMP_CEIL;
        end else begin
            if (wr_low_w) thr_low_reg <= i_reg_wdata;
            if (wr_high_w) thr_high_reg <= i_reg_wdata;
            if (wr_int_w) int_func_reg <= i_reg_wdata;
            if (wr_pwr_w) power_reg <= i_reg_wdata;
            if (wr_cfg_w) config_reg <= i_reg_wdata;
            if (wr_floor_w) imp_floor_reg <= i_reg_wdata;
            if (wr_ceil_w) imp_ceil_reg <= i_reg_wdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge rst_n_reg) begin
        if (!rst_n_reg) begin
            pending_reg <= RST_ZERO;
            prox_reg <= RST_ZERO;
            new_data_reg <= 1'b0;
            comp_reg <= 1'b0;
            wake_reg <= 1'b0;
            overload_reg <= 1'b0;
            rdata_reg <= RST_ZERO;
        end else begin
            if (conv_pulse) pending_reg <= clip_w;
            if (rd_prox_w) prox_reg <= pending_reg;
            new_data_reg <= new_data_next;
            comp_reg <= comp_next;
            wake_reg <= wake_next;
            overload_reg <= i_osc_overload;
            if (i_reg_rd) rdata_reg <= rdata_next;
        end
    end

    // Pin is high (idle) for disabled and reserved codes
    assign o_interrupt_pin_n = (int_mode_w == INT_WAKE) ? !wake_reg :
        (int_mode_w == INT_COMP) ? comp_reg :
        (int_mode_w == INT_DRDY) ? !new_data_reg : 1'b1;
    assign o_reg_rdata = rdata_reg;
    assign o_impedance_floor_setting = imp_floor_reg;
    assign o_impedance_ceiling_setting = imp_ceil_reg;
    assign o_conversion_active_sel = active_w;

    a_low_thr_write: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        wr_low_w |=> thr_low_reg == $past(i_reg_wdata))
        else $error("low threshold not written");
    a_pin_wake_mode: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        int_mode_w == INT_WAKE |-> o_interrupt_pin_n == !wake_reg)
        else $error("pin does not show wake-up");
    a_pin_comp_mode: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        int_mode_w == INT_COMP |-> o_interrupt_pin_n == status_w[4])
        else $error("pin does not show comparator");
    a_pin_drdy_mode: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        int_mode_w == INT_DRDY |-> o_interrupt_pin_n == status_w[6])
        else $error("pin does not show data ready");
    a_standby_no_conv: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        !power_reg[0] |-> !conv_pulse)
        else $error("conversion during stand-by");
    a_overload_flag: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        i_osc_overload[*2] |-> status_w[7])
        else $error("overload not flagged");
    a_data_ready_low: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        conv_pulse |=> !status_w[6] ##1 (!status_w[6] || $past(rd_prox_w)))
        else $error("data ready not shown");
    a_wake_above: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        conv_pulse && above_w && int_mode_w == INT_WAKE
        && $stable(int_func_reg) |=> !status_w[5])
        else $error("wake-up not triggered");
    a_comp_below: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        conv_pulse && below_w |=> status_w[4] && status_w[3:0] == 4'h0)
        else $error("comparator not set below low");
    a_prox_read_only: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        !rd_prox_w |=> $stable(prox_reg))
        else $error("result changed without read");
    a_prox_read_data: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        rd_prox_w |=> o_reg_rdata == prox_reg)
        else $error("result read data differs from result register");
    a_clip_result: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        conv_pulse && i_raw_result[RAW_W-1] |=> pending_reg == RST_ZERO)
        else $error("negative result not clipped");
    a_high_thr_reset: assert property (
        @(posedge i_sys_clk) disable iff (!rst_n_reg)
        $rose(rst_n_reg) |-> thr_high_reg == RST_THR_HIGH)
        else $error("high threshold reset wrong");
endmodule : isr_status_regs

// >>> tb/isr_host_model.sv
// Purpose: Host controller model driving the register port
// Assumes: Requests launch at the falling edge, one strobe cycle each
// Notes: Keeps the host-side programming restrictions on every write
`timescale 1ns/1ps
module isr_host_model
    import isr_pkg::*;
(
    input wire logic i_sys_clk, // System clock
    input wire logic [7:0] i_reg_rdata, // Read data from device
    output logic o_reg_wr, // Write strobe
    output logic o_reg_rd, // Read strobe
    output logic [7:0] o_reg_addr, // Register address
    output logic [7:0] o_reg_wdata // Write data
);
    logic floor_set = 1'b0;
    initial begin
        o_reg_wr = 1'b0;
        o_reg_rd = 1'b0;
        o_reg_addr = 8'h00;
        o_reg_wdata = 8'h00;
    end
    task automatic bus_wr(input logic [7:0] addr, input logic [7:0] data);
        @(negedge i_sys_clk);
        o_reg_addr = addr;
        o_reg_wdata = data;
        o_reg_wr = 1'b1;
        @(negedge i_sys_clk);
        o_reg_wr = 1'b0;
    endtask : bus_wr
    // Filters interrupt, impedance and power values; other addresses, read-only ones included, pass unchanged
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        logic [7:0] d;
        d = data;
        if (addr == ADDR_INT_FUNC && !(data inside {8'h00, 8'h01, 8'h02,
                8'h04}))
            d = 8'h00;
        if (addr == ADDR_IMP_FLOOR)
            d = 8'h20 | {3'h0, data[4:0]};
        if (addr == ADDR_IMP_CEIL)
            d = {3'h0, data[4:0]};
        if (addr == ADDR_POWER)
            d = {7'h00, data[0]};
        if (addr == ADDR_POWER && data[0] && !floor_set)
            bus_wr(ADDR_IMP_FLOOR, 8'h20);
        if (addr == ADDR_IMP_FLOOR)
            floor_set = 1'b1;
        bus_wr(addr, d);
    endtask : wr
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        @(negedge i_sys_clk);
        o_reg_addr = addr;
        o_reg_rd = 1'b1;
        @(negedge i_sys_clk);
        o_reg_rd = 1'b0;
        data = i_reg_rdata;
    endtask : rd
endmodule : isr_host_model

// >>> tb/testbench.sv
// Purpose: Self-checking bench for the status and output register block
// Assumes: 10 MHz clock, inputs driven at the falling edge
// Notes: Random values come from a fixed-seed xorshift generator
`timescale 1ns/1ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
    error_cnt++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, \
    (got), (exp)); end end
module testbench;
    import isr_pkg::*;
    logic sys_clk, arst_n, reg_wr, reg_rd, osc_tick, osc_ovl, pin_n, active;
    logic [7:0] reg_addr, reg_wdata, rdata, floor_o, ceil_o, d, r, mode;
    logic [9:0] raw;
    logic cmp_exp, wake_exp, pin_exp;
    logic [31:0] rng = 32'hDD1B9112;
    int error_cnt = 0;
    int tests_run = 0;
    localparam logic [7:0] MODES [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
    localparam int PERIODS [6] = '{64, 128, 256, 512, 1024, 2048};
    localparam logic [9:0] RAWS [6] = '{10'h3FB, 10'h150, 10'h080, 10'h040,
        10'h0C1, 10'h03F};
    localparam logic [7:0] RADDR [5] = '{8'h09, 8'h0A, 8'h0B, 8'h07, 8'h30};
    localparam logic [7:0] RVAL [5] = '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00};

    isr_status_regs i_dut (.i_sys_clk(sys_clk), .i_arst_n(arst_n),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr),
        .i_reg_wdata(reg_wdata), .i_osc_tick(osc_tick),
        .i_osc_overload(osc_ovl), .i_raw_result(raw), .o_reg_rdata(rdata),
        .o_interrupt_pin_n(pin_n), .o_impedance_floor_setting(floor_o),
        .o_impedance_ceiling_setting(ceil_o),
        .o_conversion_active_sel(active));
    isr_host_model i_host (.i_sys_clk(sys_clk), .i_reg_rdata(rdata),
        .o_reg_wr(reg_wr), .o_reg_rd(reg_rd), .o_reg_addr(reg_addr),
        .o_reg_wdata(reg_wdata));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    // Negative raw codes floor at zero, large ones saturate
    function automatic logic [7:0] clip(input logic [9:0] v);
        if (v[9])
            return 8'h00;
        return (v > 10'h0FF) ? 8'hFF : v[7:0];
    endfunction : clip
    task automatic idle(input int k);
        repeat (k) @(negedge sys_clk);
    endtask : idle
    task automatic ticks(input int k);
        repeat (k) begin
            @(negedge sys_clk);
            osc_tick = 1'b1;
            @(negedge sys_clk);
            osc_tick = 1'b0;
        end
    endtask : ticks
    task automatic end_sim();
        $display("checks run %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        #(100 * 30000);
        error_cnt++;
        end_sim();
    end
    initial begin
        arst_n = 1'b0;
        osc_tick = 1'b0;
        osc_ovl = 1'b0;
        raw = 10'h000;
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk);
        arst_n = 1'b1;
        idle(4);
        `CHK({pin_n, active}, 2'b10)
        for (int i = 0; i < 5; i++) begin
            i_host.rd(RADDR[i], d);
            `CHK(d, RVAL[i])
        end
        i_host.rd(ADDR_STATUS, d);
        `CHK(d[7:4], 4'h6)
        $display("test reset values done");
        for (int i = 0; i < 4; i++) begin
            rng = xs(rng);
            i_host.wr(ADDR_THR_LOW, rng[7:0]);
            i_host.wr(ADDR_THR_HIGH, rng[15:8]);
            i_host.wr(ADDR_IMP_FLOOR, rng[23:16]);
            i_host.wr(ADDR_IMP_CEIL, rng[31:24]);
            i_host.rd(ADDR_THR_LOW, d);
            `CHK(d, rng[7:0])
            i_host.rd(ADDR_THR_HIGH, d);
            `CHK(d, rng[15:8])
            `CHK(floor_o, 8'h20 | {3'h0, rng[20:16]})
            `CHK(ceil_o, {3'h0, rng[28:24]})
        end
        $display("test random registers done");
        i_host.wr(ADDR_THR_LOW, 8'h40);
        i_host.wr(ADDR_THR_HIGH, 8'hC0);
        i_host.wr(ADDR_POWER, 8'h01);
        idle(1);
        `CHK(active, 1'b1)
        cmp_exp = 1'b0;
        wake_exp = 1'b1;
        for (int i = 0; i < 9; i++) begin
            mode = MODES[i % 4];
            rng = xs(rng);
            raw = (i < 6) ? RAWS[i] : rng[9:0];
            i_host.wr(ADDR_INT_FUNC, mode);
            i_host.wr(ADDR_CONFIG, {5'h01, 3'(i % 6 + 2)});
            if (mode != 8'h01)
                wake_exp = 1'b1;
            ticks(PERIODS[i % 6] - 4);
            i_host.rd(ADDR_STATUS, d);
            `CHK(d[6], 1'b1)
            ticks(4);
            idle(3);
            r = clip(raw);
            if (r < 8'h40)
                cmp_exp = 1'b1;
            else if (r > 8'hC0)
                cmp_exp = 1'b0;
            if (mode == 8'h01 && r > 8'hC0)
                wake_exp = 1'b0;
            i_host.rd(ADDR_STATUS, d);
            `CHK(d[6:4], {1'b0, wake_exp, cmp_exp})
            case (mode)
                8'h01: pin_exp = wake_exp;
                8'h02: pin_exp = cmp_exp;
                8'h04: pin_exp = 1'b0;
                default: pin_exp = 1'b1;
            endcase
            `CHK(pin_n, pin_exp)
            osc_ovl = 1'b1;
            i_host.rd(ADDR_STATUS, d);
            `CHK(d[7], 1'b1)
            osc_ovl = 1'b0;
            i_host.rd(ADDR_PROX, d);
            `CHK(d, r)
            i_host.rd(ADDR_STATUS, d);
            `CHK({d[7], d[6]}, 2'b01)
            $display("test conversion %0d done", i);
        end
        i_host.wr(ADDR_PROX, ~r);
        i_host.wr(ADDR_STATUS, 8'h00);
        i_host.rd(ADDR_PROX, d);
        `CHK(d, r)
        i_host.rd(ADDR_STATUS, d);
        `CHK(d[6], 1'b1)
        i_host.wr(ADDR_POWER, 8'h00);
        idle(1);
        `CHK(active, 1'b0)
        i_host.wr(ADDR_INT_FUNC, 8'h04);
        ticks(300);
        i_host.rd(ADDR_STATUS, d);
        `CHK({d[6], pin_n}, 2'b11)
        $display("test stand-by done");
        end_sim();
    end
endmodule : testbench
